/* File: core/tpw_pkg.sv */
// package: register map, field positions and constants for the pulse timer
package tpw_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_MODE = 4'h0;  // timer_mode_reg
  localparam logic [3:0] ADDR_PRESC = 4'h4;  // prescaler_reload / live count
  localparam logic [3:0] ADDR_SECOND = 4'h8;  // secondary_reload
  localparam logic [3:0] ADDR_PRIMARY = 4'hC;  // primary_reload / live count
  localparam logic [3:0] ADDR_WAVE = 4'h1;  // wave_ctrl_reg
  localparam logic [3:0] ADDR_TRIG = 4'h2;  // pulse_trigger_ctrl_reg
  localparam logic [3:0] ADDR_EXTIRQ = 4'h3;  // ext_irq_enable_reg
  localparam logic [3:0] ADDR_SRC = 4'h5;  // count source select
  localparam logic [3:0] ADDR_STAT = 4'h6;  // status
  // timer_mode_reg fields
  localparam int MODE_RUN_BIT = 7;  // count_run_bit
  localparam int MODE_OP_LSB = 4;  // op_mode_field, 2 bits
  // wave_ctrl_reg fields
  localparam int WAVE_OS_BIT = 0;  // oneshot_start_bit
  localparam int WAVE_LVL_BIT = 1;  // output_level_sel
  localparam int WAVE_SRC_BIT = 2;  // output_source_sel
  localparam int WAVE_LATCH_BIT = 3;  // port_latch_bit
  // pulse_trigger_ctrl_reg fields
  localparam int TRIG_EN_BIT = 0;  // trigger_enable_bit
  localparam int TRIG_POL_BIT = 1;  // trigger_polarity_bit
  // ext_irq_enable_reg fields
  localparam int EXT_EN_BIT = 0;  // ext_irq_input_enable
  localparam int EXT_BOTH_BIT = 1;  // both_edge_sel
  // op_mode_field encodings
  localparam logic [1:0] OP_WAVE = 2'h1;
  localparam logic [1:0] OP_ONESHOT = 2'h2;
  // count source encodings
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F2 = 2'h1;
  localparam logic [1:0] SRC_F8 = 2'h2;
  localparam logic [1:0] SRC_NBR = 2'h3;
  localparam logic [2:0] DIV8_TOP = 3'h7;
  localparam logic [7:0] RESET_RELOAD = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_PRIMARY, ST_SECONDARY} tpw_phase_e;
endpackage : tpw_pkg

/* File: core/tpw_timer.sv */
// timer with prescaler: programmable waveform and one-shot pulse modes
// Function
// R1: waveform mode toggles pin each underflow, alternating reloads
// R2: waveform start counts primary value first
// R3: sources f1, f2, f8, neighbour underflow
// R4: phase lengths (pre+1)(reload+1) source cycles
// R5: run bit starts and stops waveform counting
// R6: waveform interrupt after secondary underflow, with output
// R7: waveform writes go to reloads, applied on primary
// R8: primary and prescaler reads return live count
// R9: level select sets phase and pulse levels
// R10: source select picks toggle or port latch
// R11: source select sampled at start or interrupt
// R12: one-shot pulse from primary, secondary ignored
// R13: one-shot length (pre+1)(primary+1) source cycles
// R14: one-shot underflow reloads, clears start; stop reloads
// R15: one-shot starts by software or enabled trigger edge
// R16: trigger during one-shot ignored, ext interrupt still raised
// R17: one-shot ends at reload or software clear
// R18: one-shot interrupt with pulse end
// R19: trigger enable gates pin as one-shot trigger
// R20: polarity only used in single-edge mode
// R21: stopped writes load counter, running reload only
// R22: software orders trigger enable setup and teardown
// R23: run change takes effect at next source edge
// R24: software never changes mode and run together
// R25: idle pin rests at inactive level
module tpw_timer
  import tpw_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic nbrUnderflow,
  input wire logic extTriggerPin,
  output logic pulseOutPin,
  output logic timerIrq,
  output logic extIrq
);

  typedef struct packed {
    logic [1:0] opMode;
    logic runReq;
    logic running;
    logic oneshotStart;
    logic levelSel;
    logic srcSel;
    logic srcSelLive;
    logic portLatch;
    logic trigEn;
    logic trigPol;
    logic extEn;
    logic bothEdge;
    logic [1:0] cntSrc;
    logic [2:0] div;
    logic [CW-1:0] preRel;
    logic [CW-1:0] priRel;
    logic [CW-1:0] secRel;
    logic [CW-1:0] preAct;
    logic [CW-1:0] priAct;
    logic [CW-1:0] secAct;
    logic [CW-1:0] preCnt;
    logic [CW-1:0] mainCnt;
    tpw_phase_e phase;
    logic pinLvl;
    logic pinDly;
    logic pendIrq;
    logic trigPrev;
    logic [7:0] rdata;
    logic tIrq;
    logic eIrq;
  } tpw_state_s;

  tpw_state_s st_r;
  tpw_state_s st_nxt;

  logic tick;
  logic wrPri;
  logic wrPre;
  logic wrSec;
  logic wrWave;
  logic wrMode;
  logic trigEdge;
  logic mainUf;
  logic isWave;
  logic isOne;

  // count source select: divider taps or neighbour underflow
  always_comb begin
    unique case (st_r.cntSrc)  // R3
      SRC_F1: tick = 1'b1;
      SRC_F2: tick = st_r.div[0];
      SRC_F8: tick = (st_r.div == DIV8_TOP);
      SRC_NBR: tick = nbrUnderflow;
    endcase
  end

  assign wrPri = regWr && (regAddr == ADDR_PRIMARY);
  assign wrPre = regWr && (regAddr == ADDR_PRESC);
  assign wrSec = regWr && (regAddr == ADDR_SECOND);
  assign wrWave = regWr && (regAddr == ADDR_WAVE);
  assign wrMode = regWr && (regAddr == ADDR_MODE);
  assign isWave = (st_r.opMode == OP_WAVE);
  assign isOne = (st_r.opMode == OP_ONESHOT);
  // active edge: both edges, or the polarity-selected one
  assign trigEdge = (extTriggerPin != st_r.trigPrev) &&
    (st_r.bothEdge || (extTriggerPin == st_r.trigPol));  // R20
  assign mainUf = (st_r.preCnt == COUNT_ZERO) && (st_r.mainCnt == COUNT_ZERO);

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + 3'h1;
    st_nxt.trigPrev = extTriggerPin;
    st_nxt.tIrq = 1'b0;
    st_nxt.eIrq = st_r.extEn && (extTriggerPin != st_r.trigPrev) &&
      (st_r.bothEdge || (extTriggerPin == st_r.trigPol));  // R16
    // register writes
    if (wrMode) begin
      st_nxt.runReq = regWdata[MODE_RUN_BIT];
      st_nxt.opMode = regWdata[MODE_OP_LSB +: 2];
    end
    if (wrWave) begin
      st_nxt.levelSel = regWdata[WAVE_LVL_BIT];
      st_nxt.srcSel = regWdata[WAVE_SRC_BIT];
      st_nxt.portLatch = regWdata[WAVE_LATCH_BIT];
      if (regWdata[WAVE_OS_BIT] && st_r.running && isOne && st_r.phase == ST_IDLE) begin
        st_nxt.oneshotStart = 1'b1;  // R15
      end else if (!regWdata[WAVE_OS_BIT]) begin
        st_nxt.oneshotStart = 1'b0;
      end
    end
    if (regWr && regAddr == ADDR_TRIG) begin
      st_nxt.trigEn = regWdata[TRIG_EN_BIT];
      st_nxt.trigPol = regWdata[TRIG_POL_BIT];
    end
    if (regWr && regAddr == ADDR_EXTIRQ) begin
      st_nxt.extEn = regWdata[EXT_EN_BIT];
      st_nxt.bothEdge = regWdata[EXT_BOTH_BIT];
    end
    if (regWr && regAddr == ADDR_SRC) begin
      st_nxt.cntSrc = regWdata[1:0];
    end
    // reload registers always take writes
    if (wrPre) st_nxt.preRel = regWdata[CW-1:0];  // R7
    if (wrSec) st_nxt.secRel = regWdata[CW-1:0];  // R7
    if (wrPri) begin
      st_nxt.priRel = regWdata[CW-1:0];
      // writing primary commits the set
      st_nxt.preAct = wrPre ? regWdata[CW-1:0] : st_r.preRel;  // R7
      st_nxt.priAct = regWdata[CW-1:0];
      st_nxt.secAct = st_r.secRel;
    end
    if (isOne && !st_r.running) begin
      if (wrPre) st_nxt.preAct = regWdata[CW-1:0];
      if (wrPri) st_nxt.priAct = regWdata[CW-1:0];
    end
    // stopped writes also load the live counters
    if (!st_r.running) begin
      if (wrPre) st_nxt.preCnt = regWdata[CW-1:0];  // R21
      if (wrPri) st_nxt.mainCnt = regWdata[CW-1:0];  // R21
    end
    // trigger pin edge as one-shot start
    if (isOne && st_r.running && st_r.trigEn && st_r.extEn && trigEdge &&
        st_r.phase == ST_IDLE) begin
      st_nxt.oneshotStart = 1'b1;  // R15 R19
    end
    // pending underflow interrupt and output change
    if (st_r.pendIrq && tick) begin
      st_nxt.pendIrq = 1'b0;
      st_nxt.tIrq = 1'b1;  // R6 R18
      st_nxt.srcSelLive = st_r.srcSel;  // R11
    end
    if (tick) begin
      st_nxt.running = st_r.runReq;  // R23
      if (!st_r.running && st_r.runReq) begin
        st_nxt.srcSelLive = st_r.srcSel;  // R11
        if (isWave) begin
          st_nxt.phase = ST_PRIMARY;  // R2 R5
          st_nxt.preCnt = st_r.preAct;
          st_nxt.mainCnt = st_r.priAct;
          st_nxt.pinLvl = !st_r.levelSel;  // R9
        end
      end else if (st_r.running && !st_r.runReq) begin
        st_nxt.phase = ST_IDLE;  // R5 R14
        st_nxt.oneshotStart = 1'b0;
        st_nxt.preCnt = st_r.preAct;
        st_nxt.mainCnt = st_r.priAct;
        st_nxt.pinLvl = st_r.levelSel;  // R25
      end else if (st_r.running) begin
        if (isOne && st_r.phase == ST_IDLE && st_r.oneshotStart) begin
          st_nxt.phase = ST_PRIMARY;  // R12
          st_nxt.pinLvl = !st_r.levelSel;  // R9
          st_nxt.preCnt = st_r.preAct;
          st_nxt.mainCnt = st_r.priAct;
        end else if (isOne && st_r.phase != ST_IDLE && !st_r.oneshotStart) begin
          st_nxt.phase = ST_IDLE;  // R17 R14
          st_nxt.preCnt = st_r.preAct;
          st_nxt.mainCnt = st_r.priAct;
          st_nxt.pinLvl = st_r.levelSel;
        end else if (st_r.phase != ST_IDLE) begin
          if (st_r.preCnt != COUNT_ZERO) begin
            st_nxt.preCnt = st_r.preCnt - 1'b1;  // R4 R13
          end else begin
            st_nxt.preCnt = st_r.preAct;
            if (st_r.mainCnt != COUNT_ZERO) begin
              st_nxt.mainCnt = st_r.mainCnt - 1'b1;
            end
          end
          if (mainUf) begin
            if (isOne) begin
              st_nxt.phase = ST_IDLE;  // R14 R17
              st_nxt.oneshotStart = 1'b0;
              st_nxt.mainCnt = st_r.priAct;
              st_nxt.pendIrq = 1'b1;
              st_nxt.pinLvl = st_r.levelSel;  // R18
            end else if (st_r.phase == ST_PRIMARY) begin
              st_nxt.phase = ST_SECONDARY;  // R1
              st_nxt.mainCnt = st_r.secAct;  // R12 ignores this in one-shot
              st_nxt.pinLvl = st_r.levelSel;  // R1 R9
            end else begin
              st_nxt.phase = ST_PRIMARY;  // R1
              st_nxt.mainCnt = st_r.priAct;
              st_nxt.pendIrq = 1'b1;  // R6
              st_nxt.pinLvl = !st_r.levelSel;  // R1 R9
            end
          end
        end
      end
    end
    // pin trails the phase level by one tick, so each irq meets its pin edge
    if (st_r.phase == ST_IDLE && !st_r.pendIrq) begin
      st_nxt.pinDly = st_r.levelSel;  // R25
    end else if (tick) begin
      st_nxt.pinDly = st_r.pinLvl;  // R6 R18
    end
    // read port: primary and prescaler return live count
    st_nxt.rdata = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        ADDR_MODE: st_nxt.rdata = {st_r.running, 1'b0, st_r.opMode, 4'h0};
        ADDR_WAVE: st_nxt.rdata = {4'h0, st_r.portLatch, st_r.srcSel,
                                   st_r.levelSel, st_r.oneshotStart};
        ADDR_TRIG: st_nxt.rdata = {6'h00, st_r.trigPol, st_r.trigEn};
        ADDR_EXTIRQ: st_nxt.rdata = {6'h00, st_r.bothEdge, st_r.extEn};
        ADDR_SRC: st_nxt.rdata = {6'h00, st_r.cntSrc};
        ADDR_PRESC: st_nxt.rdata = 8'(st_r.preCnt);  // R8
        ADDR_PRIMARY: st_nxt.rdata = 8'(st_r.mainCnt);  // R8
        ADDR_SECOND: st_nxt.rdata = 8'(st_r.secRel);
        ADDR_STAT: st_nxt.rdata = {5'h00, st_r.pendIrq, st_r.phase};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register with clock enable
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.preRel <= RESET_RELOAD;
      st_r.priRel <= RESET_RELOAD;
      st_r.secRel <= RESET_RELOAD;
      st_r.preAct <= RESET_RELOAD;
      st_r.priAct <= RESET_RELOAD;
      st_r.secAct <= RESET_RELOAD;
      st_r.preCnt <= RESET_RELOAD;
      st_r.mainCnt <= RESET_RELOAD;
      st_r.phase <= ST_IDLE;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // pin: toggle waveform or port latch copy
  assign pulseOutPin = (isWave && st_r.srcSelLive) ? st_r.portLatch : st_r.pinDly;  // R10
  assign timerIrq = st_r.tIrq;
  assign extIrq = st_r.eIrq;
  assign regRdata = st_r.rdata;

  // checks

  // one-shot underflow ends the pulse and clears the start bit
  a_oneshot_clear: assert property (@(posedge clk) disable iff (srst)  // R14
    clkEn && tick && isOne && st_r.running && st_r.runReq && st_r.phase != ST_IDLE &&
    st_r.oneshotStart && mainUf |=> !st_r.oneshotStart && st_r.phase == ST_IDLE)
    else $error("one-shot did not end on underflow");

  // timer irq only follows a pending underflow
  a_irq_pending: assert property (@(posedge clk) disable iff (srst)  // R6
    timerIrq |-> $past(st_r.pendIrq))
    else $error("timer irq without pending underflow");

  // timer irq is a single-cycle pulse
  a_irq_single: assert property (@(posedge clk) disable iff (srst)  // R6
    clkEn && timerIrq |=> !timerIrq)
    else $error("timer irq longer than one cycle");

  // waveform irq lands with the change back to the primary level
  a_wave_irq_edge: assert property (@(posedge clk) disable iff (srst)  // R6
    isWave && timerIrq && !st_r.srcSelLive && !$past(st_r.srcSelLive) &&
    $stable(st_r.levelSel) |-> pulseOutPin == !st_r.levelSel &&
    $past(pulseOutPin) == st_r.levelSel)
    else $error("waveform irq not with output change");

  // one-shot irq lands with the end of the pulse
  a_oneshot_irq_end: assert property (@(posedge clk) disable iff (srst)  // R18
    isOne && timerIrq |-> pulseOutPin == st_r.levelSel)
    else $error("one-shot irq before pulse end");

  // stop reloads the counter on the same tick that halts it
  a_stop_reload: assert property (@(posedge clk) disable iff (srst)  // R14
    clkEn && tick && st_r.running && !st_r.runReq |=> st_r.phase == ST_IDLE &&
    st_r.mainCnt == st_r.priAct)
    else $error("stop did not reload counter");

  // waveform start enters the primary phase
  a_wave_start: assert property (@(posedge clk) disable iff (srst)  // R2
    clkEn && tick && isWave && !st_r.running && st_r.runReq |=> st_r.phase == ST_PRIMARY)
    else $error("waveform did not start in primary");

  // run state follows the request at a source edge
  a_run_follow: assert property (@(posedge clk) disable iff (srst)  // R23
    clkEn && tick |=> st_r.running == $past(st_r.runReq))
    else $error("run state missed source edge");

  // stopped primary write loads the live counter
  a_stopped_write: assert property (@(posedge clk) disable iff (srst)  // R21
    clkEn && wrPri && !st_r.running |=> st_r.mainCnt == $past(regWdata))
    else $error("stopped write missed counter");

  // idle pin rests at the inactive level
  a_idle_level: assert property (@(posedge clk) disable iff (srst)  // R25
    isOne && st_r.phase == ST_IDLE && !st_r.pendIrq && $stable(st_r.levelSel) &&
    $past(st_r.phase) == ST_IDLE |-> pulseOutPin == st_r.levelSel)
    else $error("idle pin not inactive");

  // every active edge raises the external irq while its input is enabled
  a_ext_irq: assert property (@(posedge clk) disable iff (srst)  // R16
    clkEn && st_r.extEn && trigEdge |=> extIrq)
    else $error("ext irq missing");

  // start bit refused while stopped
  a_os_refused: assert property (@(posedge clk) disable iff (srst)  // R15
    clkEn && wrWave && regWdata[WAVE_OS_BIT] && !st_r.running |=> !st_r.oneshotStart)
    else $error("one-shot armed while stopped");

  // trigger pin cannot arm a one-shot when disabled
  a_trig_disabled: assert property (@(posedge clk) disable iff (srst)  // R19
    clkEn && isOne && !st_r.trigEn && !st_r.oneshotStart && !wrWave |=> !st_r.oneshotStart)
    else $error("disabled trigger armed one-shot");

  // read data stands only in the cycle after a read
  a_rdata_idle: assert property (@(posedge clk) disable iff (srst)  // R8
    clkEn && !regRd |=> regRdata == 8'h00)
    else $error("read data outside read slot");

  // low clock enable freezes all state
  a_freeze: assert property (@(posedge clk) disable iff (srst)  // R4
    !clkEn |=> $stable(st_r))
    else $error("state moved with clock enable low");

  // main scenarios
  c_wave_period: cover property (@(posedge clk) isWave && timerIrq);
  c_oneshot_done: cover property (@(posedge clk) isOne && timerIrq);
  c_trig_ignored: cover property (@(posedge clk) isOne && st_r.phase != ST_IDLE && extIrq);
  c_wave_latch: cover property (@(posedge clk) isWave && st_r.running && st_r.srcSelLive);
  c_sw_clear: cover property (@(posedge clk)
    isOne && wrWave && !regWdata[WAVE_OS_BIT] && st_r.phase != ST_IDLE);

endmodule : tpw_timer

/* File: verification/timer_pulse_waveform_oneshot_tb.sv */
// self-checking bench for the pulse timer: waveform and one-shot modes
module timer_pulse_waveform_oneshot_tb
  import tpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, clkEn, regWr, regRd, nbrUnderflow = 1'b0, extTriggerPin;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, v;
  logic pulseOutPin, timerIrq, extIrq;
  logic [1:0] nbrDiv = 2'h0;
  logic got [2];
  logic [1:0] srcs [4] = '{SRC_F1, SRC_F2, SRC_F8, SRC_NBR};
  int divs [4] = '{1, 2, 8, 3};
  int numErrors = 0, checkCount = 0, cycles = 0, irqCnt = 0, extCnt = 0, highCnt = 0;
  int hi, lo, n, w, pre, pri, sec, p;
  tpw_timer #(.CW(8)) uut (.clk(clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .nbrUnderflow(nbrUnderflow), .extTriggerPin(extTriggerPin), .pulseOutPin(pulseOutPin),
    .timerIrq(timerIrq), .extIrq(extIrq));
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // neighbour underflow every third cycle
  always @(posedge clk) begin
    nbrDiv <= (nbrDiv == 2'h2) ? 2'h0 : nbrDiv + 2'h1;
    nbrUnderflow <= (nbrDiv == 2'h2);
  end
  // event counters and hang guard, sampled away from the launch edge
  always @(negedge clk) begin
    cycles++;
    if (timerIrq === 1'b1) irqCnt++;
    if (extIrq === 1'b1) extCnt++;
    if (pulseOutPin === 1'b1) highCnt++;
    if (cycles == 30000) begin
      numErrors++;
      conclude();
    end
  end
  task automatic conclude();
    if (numErrors == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  function automatic logic [7:0] modeV(input logic run, input logic [1:0] op);
    return (8'(run) << MODE_RUN_BIT) | (8'(op) << MODE_OP_LSB);
  endfunction : modeV
  // cycles until the pin reaches a level, bounded
  task automatic waitlvl(input logic lv, output int cnt);
    cnt = 0;
    while (pulseOutPin !== lv && cnt < 3000) begin
      @(posedge clk);
      #1 cnt++;
    end
    if (cnt >= 3000) check(16'h0, 16'h1);
  endtask : waitlvl
  // one full period: primary level is the inverse of the level select
  task automatic phases(input logic l, output int h, output int s);
    int t;
    waitlvl(!l, t);
    waitlvl(l, h);
    waitlvl(!l, s);
  endtask : phases
  task automatic cfgWave(input logic [1:0] s, input logic [7:0] wc, input int pr, pm, sc);
    wr(ADDR_MODE, modeV(1'b0, OP_WAVE));
    wr(ADDR_SRC, 8'(s));
    wr(ADDR_WAVE, wc);
    wr(ADDR_PRESC, 8'(pr));
    wr(ADDR_SECOND, 8'(sc));
    wr(ADDR_PRIMARY, 8'(pm));
    wr(ADDR_MODE, modeV(1'b1, OP_WAVE));
  endtask : cfgWave
  task automatic stopOne();
    wr(ADDR_MODE, modeV(1'b0, OP_ONESHOT));
  endtask : stopOne
  // main sequence
  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    extTriggerPin = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    void'($urandom(32'h8B89));
    // reset state and unmapped place
    rd(ADDR_PRIMARY, v); check(v, RESET_RELOAD);
    rd(ADDR_PRESC, v); check(v, RESET_RELOAD);
    @(posedge clk);
    #1 check(regRdata, 8'h00);
    check(pulseOutPin, 1'b0);
    wr(4'hF, 8'hA5);
    rd(4'hF, v); check(v, 8'h00);
    // waveform lengths for every count source and both levels
    for (int i = 0; i < 4; i++) begin
      pre = $urandom_range(2);
      pri = $urandom_range(5);
      sec = $urandom_range(5);
      cfgWave(srcs[i], 8'(i % 2) << WAVE_LVL_BIT, pre, pri, sec);
      phases(i % 2, hi, lo);
      phases(i % 2, hi, lo);
      check(hi, (pre + 1) * (pri + 1) * divs[i]);
      check(lo, (pre + 1) * (sec + 1) * divs[i]);
      irqCnt = 0;
      repeat (hi + lo) @(posedge clk);
      #1 check(irqCnt, 1);
    end
    // reload writes wait for the primary write
    cfgWave(SRC_F1, 8'h00, 0, 3, 3);
    wr(ADDR_SECOND, 8'h07);
    phases(1'b0, hi, lo);
    phases(1'b0, hi, lo);
    check(hi, 4);
    check(lo, 4);
    wr(ADDR_PRIMARY, 8'h05);
    phases(1'b0, hi, lo);
    phases(1'b0, hi, lo);
    check(hi, 6);
    check(lo, 8);
    rd(ADDR_PRIMARY, v); check(v <= 8'h05, 1'b1);
    rd(ADDR_PRESC, v); check(v, 8'h00);
    // clock enable low freezes the running waveform
    @(posedge clk);
    clkEn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 highCnt = 0;
    v[0] = pulseOutPin;
    repeat (20) @(posedge clk);
    #1 check(highCnt, v[0] ? 16'h14 : 16'h00);
    @(posedge clk);
    clkEn <= 1'b1;
    // port latch drives the pin instead of toggling
    cfgWave(SRC_F1, (8'h1 << WAVE_SRC_BIT) | (8'h1 << WAVE_LATCH_BIT), 0, 2, 2);
    repeat (4) @(posedge clk);
    #1 highCnt = 0;
    repeat (60) @(posedge clk);
    #1 check(highCnt, 60);
    // one-shot by software
    wr(ADDR_MODE, modeV(1'b0, OP_WAVE));
    stopOne();
    p = 1 + $urandom_range(19);
    wr(ADDR_WAVE, 8'h00);
    wr(ADDR_PRESC, 8'h00);
    wr(ADDR_PRIMARY, 8'(p));
    wr(ADDR_WAVE, 8'h1 << WAVE_OS_BIT);
    rd(ADDR_WAVE, v); check(v[WAVE_OS_BIT], 1'b0);
    wr(ADDR_MODE, modeV(1'b1, OP_ONESHOT));
    repeat (3) @(posedge clk);
    #1 irqCnt = 0;
    check(pulseOutPin, 1'b0);
    wr(ADDR_WAVE, 8'h1 << WAVE_OS_BIT);
    waitlvl(1'b1, n);
    waitlvl(1'b0, w);
    check(w, p + 1);
    repeat (3) @(posedge clk);
    #1 check(irqCnt, 1);
    rd(ADDR_WAVE, v); check(v[WAVE_OS_BIT], 1'b0);
    rd(ADDR_PRIMARY, v); check(v, 8'(p));
    // external trigger, both edges; second edge mid-pulse ignored
    wr(ADDR_PRIMARY, 8'h14);
    wr(ADDR_EXTIRQ, (8'h1 << EXT_EN_BIT) | (8'h1 << EXT_BOTH_BIT));
    wr(ADDR_TRIG, 8'h1 << TRIG_EN_BIT);
    extCnt = 0;
    @(posedge clk);
    extTriggerPin <= 1'b1;
    waitlvl(1'b1, n);
    extTriggerPin <= 1'b0;
    waitlvl(1'b0, w);
    check(w, 21);
    check(extCnt, 2);
    // software clear ends a running pulse
    wr(ADDR_WAVE, 8'h1 << WAVE_OS_BIT);
    waitlvl(1'b1, n);
    wr(ADDR_WAVE, 8'h00);
    waitlvl(1'b0, w);
    check(w < 8, 1'b1);
    // trigger enable off: edge raises only the external interrupt
    stopOne();
    wr(ADDR_TRIG, 8'h00);
    wr(ADDR_MODE, modeV(1'b1, OP_ONESHOT));
    extCnt = 0;
    highCnt = 0;
    @(posedge clk);
    extTriggerPin <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check(highCnt, 0);
    check(extCnt, 1);
    // single-edge mode: polarity picks whether a rising edge fires
    for (int k = 0; k < 2; k++) begin
      stopOne();
      wr(ADDR_TRIG, 8'h00);
      wr(ADDR_EXTIRQ, 8'h1 << EXT_EN_BIT);
      wr(ADDR_TRIG, 8'(k) << TRIG_POL_BIT);
      wr(ADDR_TRIG, (8'(k) << TRIG_POL_BIT) | (8'h1 << TRIG_EN_BIT));
      wr(ADDR_MODE, modeV(1'b1, OP_ONESHOT));
      extTriggerPin <= 1'b0;
      repeat (40) @(posedge clk);
      #1 highCnt = 0;
      extTriggerPin <= 1'b1;
      repeat (40) @(posedge clk);
      #1 got[k] = (highCnt > 0);
    end
    check(got[0] ^ got[1], 1'b1);
    conclude();
  end
endmodule : timer_pulse_waveform_oneshot_tb
